// *** design/epgc_pkg.sv ***
// package: register map and field layout of the eight pin control block
package epgc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_PINS = 8;
    localparam int unsigned SLICE_W = 4;
    localparam logic [7:0] PIN_IO_CONTROL_OFFSET = 8'hB8;
    localparam int unsigned IN_BIT = 0;
    localparam int unsigned DIR_BIT = 1;
    localparam int unsigned OUT_BIT = 2;
    localparam int unsigned RSVD_BIT = 3;
    localparam int unsigned LANE_W = 8;
    localparam logic RSVD_READ = 1'b0;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'h00;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;
    localparam int unsigned SYNC_STAGES = 2;
endpackage

// *** design/epgc_gpio.sv ***
// module: apb slave holding the eight pin control register and its pin logic
//
// Function
// RL1 - bit 4n reads the synchronised level of pin n; writes ignored
// RL2 - bit 4n+1 sets pin n direction: 0 input undriven, 1 output
// RL3 - bit 4n+2 value drives pin n only while its direction is output
// RL4 - reset clears all direction and output bits, pins start undriven
// RL5 - exactly eight pins; bits 3,7,...,31 reserved and read zero
// RL6 - register sits at offset B8h, upstream port only
// RL7 - pin inputs pass two flip-flops before reaching the input bit
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module epgc_gpio #(
    parameter int unsigned NUM_PINS = epgc_pkg::NUM_PINS,
    parameter bit UPSTREAM_PORT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // stages the input synchroniser is built with
    localparam int unsigned SYNC_BUILT = 2;

    // the register word holds exactly one slice per pin
    generate
        if (NUM_PINS != epgc_pkg::NUM_PINS) begin : g_bad_pins
            $error("epgc_gpio: register holds exactly eight pin slices");
        end
        if (NUM_PINS * epgc_pkg::SLICE_W != epgc_pkg::DATA_W) begin : g_bad_map
            $error("epgc_gpio: pin slices must fill the data word");
        end
        if (epgc_pkg::SYNC_STAGES != SYNC_BUILT) begin : g_bad_sync
            $error("epgc_gpio: synchroniser depth differs from the built chain");
        end
        // a slice that straddled two byte lanes could be half written
        if (epgc_pkg::LANE_W % epgc_pkg::SLICE_W != 0) begin : g_bad_lane
            $error("epgc_gpio: pin slices must not straddle byte lanes");
        end
        if (epgc_pkg::RSVD_BIT >= epgc_pkg::SLICE_W) begin : g_bad_field
            $error("epgc_gpio: field positions must lie inside a slice");
        end
        if ($bits(epgc_pkg::DIR_RESET) < NUM_PINS || $bits(epgc_pkg::OUT_RESET) < NUM_PINS) begin : g_bad_rst
            $error("epgc_gpio: reset values must cover every pin");
        end
        if (epgc_pkg::PIN_IO_CONTROL_OFFSET % (epgc_pkg::DATA_W / epgc_pkg::LANE_W) != 0) begin : g_bad_ofs
            $error("epgc_gpio: register offset must be word aligned");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // position of one field inside the slice of a pin
    function automatic int unsigned field_pos(
        input int unsigned pin,
        input int unsigned field
    );
        return pin * epgc_pkg::SLICE_W + field;
    endfunction

    // byte lane enable that guards one register bit
    function automatic logic lane_on(
        input logic [3:0] strb,
        input int unsigned bit_pos
    );
        return strb[bit_pos / epgc_pkg::LANE_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    // software-visible registers
    logic [NUM_PINS-1:0] dir_r;
    logic [NUM_PINS-1:0] out_r;

    // synchroniser stages
    logic [NUM_PINS-1:0] sync1_r;
    logic [NUM_PINS-1:0] sync2_r;

    // combinational
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] lane_wr;
    logic [31:0] reg_view;
    logic [31:0] prdata_nxt;
    logic hit;
    logic setup_rd;
    logic wr_en;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // downstream instances leave the address unmapped
    assign hit = UPSTREAM_PORT && (paddr == epgc_pkg::PIN_IO_CONTROL_OFFSET); // RL6

    // writes land in the access phase, when the transfer completes
    assign wr_en = psel && penable && pwrite && hit;

    // read data is captured in setup so the access needs no wait
    assign setup_rd = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // bus answer

    // single register, no wait states
    assign pready = 1'b1;

    // unmapped offsets read zero rather than flag an error
    assign pslverr = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // input synchroniser

    // pins are asynchronous to pclk; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
        end else begin
            sync1_r <= pin_in; // RL7
        end
    end

    // second stage is the only reader of the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync2_r <= '0;
        end else begin
            sync2_r <= sync1_r; // RL7
        end
    end

    // level software sees; metastability settles in the first stage
    assign pin_level = sync2_r; // RL7

    ////////////////////////////////////////////////////////////////////////////
    // per pin slice

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            // bit positions of this pin's fields
            localparam int unsigned IB = field_pos(g, epgc_pkg::IN_BIT);
            localparam int unsigned DB = field_pos(g, epgc_pkg::DIR_BIT);
            localparam int unsigned OB = field_pos(g, epgc_pkg::OUT_BIT);
            localparam int unsigned RB = field_pos(g, epgc_pkg::RSVD_BIT);

            // both fields of a pin share one byte lane
            assign lane_wr[g] = wr_en && lane_on(pstrb, DB);

            // direction starts cleared so no pin drives out of reset
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir_r[g] <= epgc_pkg::DIR_RESET[g]; // RL4
                end else if (lane_wr[g]) begin
                    dir_r[g] <= pwdata[DB]; // RL2
                end
            end

            // output value kept while the pin is an input, ready for turn-on
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_r[g] <= epgc_pkg::OUT_RESET[g]; // RL4
                end else if (lane_wr[g]) begin
                    out_r[g] <= pwdata[OB]; // RL3
                end
            end

            // pad enable follows the direction bit
            assign pin_oe[g] = dir_r[g]; // RL2

            // a released pin shows low so the pad never sees a stale value
            assign pin_out[g] = dir_r[g] & out_r[g]; // RL3

            // register view of this slice; writes to the input bit are dropped
            assign reg_view[IB] = pin_level[g]; // RL1
            assign reg_view[DB] = dir_r[g];
            assign reg_view[OB] = out_r[g];
            // reserved bit has no storage
            assign reg_view[RB] = epgc_pkg::RSVD_READ; // RL5
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read data

    // unmapped or downstream offsets read back zero
    always_comb begin
        prdata_nxt = epgc_pkg::RDATA_UNMAPPED;
        if (hit) begin
            prdata_nxt = reg_view; // RL1
        end else begin
            prdata_nxt = epgc_pkg::RDATA_UNMAPPED; // RL6
        end
    end

    // held between reads; a late pin change shows on the next read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= epgc_pkg::RDATA_UNMAPPED;
        end else if (setup_rd) begin
            prdata <= prdata_nxt;
        end
    end

endmodule // epgc_gpio
`default_nettype wire

// *** bench/epgc_asserts.sv ***
// checker: pin control register properties
`timescale 1ns/1ns
`default_nettype none
module epgc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite && paddr == 8'hB8;
    wire logic rd = psel && !penable && !pwrite;
    wire logic rdu = rd && paddr == 8'hB8;
    a_pin_gated: assert property (pin_out == (pin_out & pin_oe))
        else $error("undriven");
    a_dir_take: assert property (wr && pstrb[3] |=> pin_oe[7] == $past(pwdata[29]))
        else $error("dir");
    a_out_take: assert property (wr && pstrb[0] |=> pin_out[0] == ($past(pwdata[2]) && $past(pwdata[1])))
        else $error("out");
    a_reset_idle: assert property ($rose(presetn) |-> pin_oe == 8'h00)
        else $error("rst");
    a_in_sync: assert property (rdu && $past(presetn, 2) |=> prdata[0] == $past(pin_in[0], 3))
        else $error("sync");
    a_rsvd_zero: assert property ((prdata & 32'h88888888) == 32'h00000000)
        else $error("rsvd");
    a_unmapped: assert property (rd && paddr != 8'hB8 |=> prdata == 32'h00000000)
        else $error("map");
    c_write: cover property (wr);
    c_read: cover property (rdu);
    c_drive: cover property (pin_oe == 8'hFF);
    c_lane: cover property (wr && pstrb != 4'hF);
endmodule // epgc_chk
`default_nettype wire

// *** bench/epgc_board.sv ***
// partner: board wire resolving each pin level
`timescale 1ns/1ns
`default_nettype none
module epgc_board (
    input wire logic [7:0] oe,
    input wire logic [7:0] drv,
    input wire logic [7:0] ext,
    output logic [7:0] lvl
);
    // board source loses wherever the block drives
    assign lvl = (oe & drv) | (~oe & ext);
endmodule // epgc_board
`default_nettype wire

// *** bench/test_eight_pin_gpio_control.sv ***
// testbench: register access and pin behaviour
`timescale 1ns/1ns
`default_nettype none
module test_eight_pin_gpio_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] ext = 8'hA5;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [31:0] rd;
    int fails = 0;
    int n_compared = 0;
    epgc_gpio u_epgc_gpio (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );
    epgc_board u_epgc_board (
        .oe(pin_oe),
        .drv(pin_out),
        .ext(ext),
        .lvl(pin_in)
    );
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t %h %h", $time, s, e);
        end
    endtask
    task automatic close_out;
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // holds the request until pready is seen; pslverr is checked at the next falling edge, where the task returns for pin checks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 8);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
        chk(32'(pslverr), 32'h00000000);
        if (i >= 8) begin
            fails++;
            close_out;
        end
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(32'({pin_oe, pin_out}), 32'h00000000);
        // read at once: the level has not yet crossed both stages
        apb(1'b0, 8'hB8, 32'h00000000, 4'hF);
        chk(rd, 32'h00000000);
        apb(1'b0, 8'hB8, 32'h00000000, 4'hF);
        chk(rd, 32'h10100101);
        apb(1'b1, 8'hB8, 32'hFFFFFFFF, 4'hF);
        chk(32'({pin_oe, pin_out}), 32'h0000FFFF);
        apb(1'b1, 8'hBC, 32'h00000000, 4'hF);
        apb(1'b0, 8'hBC, 32'h00000000, 4'hF);
        chk(rd, 32'h00000000);
        apb(1'b0, 8'hB8, 32'h00000000, 4'hF);
        chk(rd, 32'h77777777);
        apb(1'b1, 8'hB8, 32'h44444444, 4'hF);
        chk(32'({pin_oe, pin_out}), 32'h00000000);
        // first read still sees the old synchronised levels
        apb(1'b0, 8'hB8, 32'h00000000, 4'hF);
        apb(1'b0, 8'hB8, 32'h00000000, 4'hF);
        chk(rd, 32'h54544545);
        // lane 0 only: pins 0 and 1 turn to driven outputs
        apb(1'b1, 8'hB8, 32'h00000066, 4'h1);
        chk(32'({pin_oe, pin_out}), 32'h00000303);
        apb(1'b0, 8'hB8, 32'h00000000, 4'hF);
        apb(1'b0, 8'hB8, 32'h00000000, 4'hF);
        chk(rd, 32'h54544577);
        close_out;
    end
endmodule // test_eight_pin_gpio_control
bind epgc_gpio epgc_chk u_epgc_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
);
`default_nettype wire
